// [epgrf_map.vh]
`ifndef EPGRF_MAP_VH
`define EPGRF_MAP_VH

// Register byte offsets
`define EPGRF_OFF_FILT    8'h00
`define EPGRF_OFF_PCTL    8'h04
`define EPGRF_OFF_QUANTA  8'h08
`define EPGRF_OFF_STA_LO  8'h0c
`define EPGRF_OFF_STA_HI  8'h10
`define EPGRF_OFF_STATUS  8'h14

// Filter control fields
`define EPGRF_F_ALL     0
`define EPGRF_F_RUNT    1
`define EPGRF_F_DST     2
`define EPGRF_F_PAUSE   4
`define EPGRF_F_CTRL    5
`define EPGRF_FILT_W    6
`define EPGRF_FILT_RST  6'h31

// Pause control fields
`define EPGRF_P_XON     0
`define EPGRF_P_XOFF    1

// Reset values
`define EPGRF_QUANTA_RST 16'hffff

// Frame constants
`define EPGRF_ETYPE      16'h8808
`define EPGRF_OPC_PAUSE  16'h0001
`define EPGRF_MCAST_DA   48'h0180c2000001
`define EPGRF_FRAME_LAST 3'h7
`define EPGRF_MIN_WORDS  4'h8

// Timing: one quantum is 512 bit times on a 64-bit path
`define EPGRF_QUANTUM_BITS 512
`define EPGRF_DATA_W       64
`define EPGRF_QUANTUM_CYC  (`EPGRF_QUANTUM_BITS / `EPGRF_DATA_W)

// Store-and-forward buffer
`define EPGRF_BUF_AW  8
`define EPGRF_BUF_W   66

`endif

// [epgrf_partner.sv]
`timescale 1ns/100ps
// ========================================
// Remote link partner and local TX MAC side
module epgrf_partner (
  input  wire        clk, // Clock
  input  wire        gen_valid, // Pause valid
  input  wire        gen_sop, // Pause first
  input  wire [63:0] gen_data, // Pause word
  input  wire        rx_pause_hit, // Match
  input  wire [15:0] rx_pause_time, // Match quanta
  output reg  [63:0] rx_data, // RX word
  output reg         rx_valid, // RX valid
  output reg         rx_sop, // RX first
  output reg         rx_eop, // RX last
  output reg         tx_flowctl_hit, // Timer load
  output reg  [15:0] tx_flowctl_duration // Timer quanta
);
  reg [63:0] w [0:7];
  integer    n_frm;
  integer    k;
  initial begin
    rx_data = 64'h0;
    rx_valid = 1'b0;
    rx_sop = 1'b0;
    rx_eop = 1'b0;
    tx_flowctl_hit = 1'b0;
    tx_flowctl_duration = 16'h0;
    n_frm = 0;
    k = 0;
  end
  // Matches drive the local TX timer, as in a duplex MAC
  always @(posedge clk) begin
    tx_flowctl_hit <= (rx_pause_hit === 1'b1);
    tx_flowctl_duration <= (rx_pause_hit === 1'b1) ? rx_pause_time : ~tx_flowctl_duration;
    if (gen_valid === 1'b1) begin
      if (gen_sop === 1'b1) begin
        n_frm = n_frm + 1;
        k = 0;
      end
      w[k] = gen_data;
      k = (k + 1) % 8;
    end
  end
  task send(input [47:0] da, input [15:0] et, input [15:0] op, input [15:0] q);
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        rx_data <= (i == 0) ? {da, 16'h5a01} : (i == 1) ? {32'h5a5a0102, et, op} :
                   (i == 2) ? {q, 48'h0} : 64'h0;
        rx_valid <= 1'b1;
        rx_sop <= (i == 0);
        rx_eop <= (i == 7);
        @(posedge clk);
      end
      rx_valid <= 1'b0;
      rx_sop <= 1'b0;
      rx_eop <= 1'b0;
      rx_data <= ~rx_data;
      @(posedge clk);
    end
  endtask
endmodule

// [epgrf_top.v]
`timescale 1ns/100ps
// Behaviour
// (RQ1) Client request, zero time: XON after frame
// (RQ2) Pause control write queues XON frame
// (RQ3) Pause bytes carry configured quanta value
// (RQ4) Each request edge is one insertion
// (RQ5) Client supplies 16-bit time in quanta
// (RQ6) Multicast select picks fixed address else client
// (RQ7) Source address from client input
// (RQ8) Matching received pause raises match output
// (RQ9) Received pause time on 16-bit output
// (RQ10) TX match and time suspend transmission
// (RQ11) Filter bit 4 controls pause filtering
// (RQ12) Filter bit 5 controls control filtering
// (RQ13) Pause and control filter bits reset one
// (RQ14) Bit 0 gates all filter bits
// (RQ15) Pause filtering drops 0x8808 opcode 1
// (RQ16) Control filtering drops other 0x8808 opcodes
// (RQ17) Unfiltered pause follows destination address filter
// (RQ18) Pass-through leaves pause reaction unchanged
// (RQ19) No filtering besides runt: cut-through
// (RQ20) Any other filtering: store and forward
// (RQ21) Cut-through accepts every identifiable frame
// (RQ22) Nonzero client time: XOFF after frame
// (RQ23) One quantum equals eight clock cycles
// (RQ24) Resume on expiry or zero; newest replaces
// (RQ25) Latch request fields, hold one pending
`include "epgrf_map.vh"

module epgrf_top (
  input  wire        clk,                 // 20 MHz clock
  input  wire        rst,                 // Async reset, high
  input  wire        ce,                  // Clock enable
  input  wire        wb_cyc_i,            // Wishbone cycle
  input  wire        wb_stb_i,            // Wishbone strobe
  input  wire        wb_we_i,             // Wishbone write
  input  wire [7:0]  wb_adr_i,            // Byte address
  input  wire [3:0]  wb_sel_i,            // Byte lanes
  input  wire [31:0] wb_dat_i,            // Write data
  output reg  [31:0] wb_dat_o,            // Read data
  output reg         wb_ack_o,            // Acknowledge
  input  wire        pause_req,           // Client request edge
  input  wire [15:0] pause_req_time,      // Quanta, zero is XON
  input  wire        pause_req_mcast,     // Use multicast address
  input  wire [47:0] pause_req_dst,       // Unicast destination
  input  wire [47:0] pause_req_src,       // Source address
  input  wire        tx_busy,             // TX frame in progress
  output reg  [63:0] gen_data,            // Pause frame word
  output reg         gen_valid,           // Pause word valid
  output reg         gen_sop,             // First word
  output reg         gen_eop,             // Last word
  input  wire        tx_flowctl_hit,      // Tx_flowctl_hit
  input  wire [15:0] tx_flowctl_duration, // Tx_flowctl_duration
  output reg         tx_halt,             // TX suspended
  input  wire [63:0] rx_data,             // RX MAC word
  input  wire        rx_valid,            // RX word valid
  input  wire        rx_sop,              // RX first word
  input  wire        rx_eop,              // RX last word
  output reg         rx_pause_hit,        // Pause match pulse
  output reg  [15:0] rx_pause_time,       // Received quanta
  output reg  [63:0] cl_data,             // Client word
  output reg         cl_valid,            // Client word valid
  output reg         cl_sop,              // Client first word
  output reg         cl_eop               // Client last word
);

  // ==========================================
  // Functions
  function [31:0] lane_mask;
    input [31:0] old;
    input [31:0] val;
    input [3:0]  sel;
    integer i;
    begin
      lane_mask = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          lane_mask[i*8 +: 8] = val[i*8 +: 8];
        end
      end
    end
  endfunction

  function [63:0] frame_word;
    input [2:0]  idx;
    input [47:0] da;
    input [47:0] sa;
    input [15:0] qt;
    begin
      case (idx)
        3'h0: frame_word = {da, sa[47:32]};
        3'h1: frame_word = {sa[31:0], `EPGRF_ETYPE, `EPGRF_OPC_PAUSE};
        3'h2: frame_word = {qt, 48'h0};
        default: frame_word = 64'h0;
      endcase
    end
  endfunction

  // ==========================================
  // Registers and bus slave
  reg [`EPGRF_FILT_W-1:0] filt;
  reg [15:0]              quanta;
  reg [47:0]              station;
  reg                     sw_xon;
  reg                     sw_xoff;
  reg                     pend;
  reg                     sending;
  reg                     store_frame;
  reg [8:0]               wp;
  reg [8:0]               cp;
  reg [8:0]               rp;

  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr  = wb_req & wb_we_i;
  wire buf_busy = (rp != cp);

  wire gate      = filt[`EPGRF_F_ALL];                      // [RQ14]
  wire f_pause   = gate & filt[`EPGRF_F_PAUSE];             // [RQ11] [RQ14]
  wire f_ctrl    = gate & filt[`EPGRF_F_CTRL];              // [RQ12] [RQ14]
  wire f_dst     = gate & filt[`EPGRF_F_DST];
  wire f_runt    = gate & filt[`EPGRF_F_RUNT];
  wire store_mode = f_pause | f_ctrl | f_dst;               // [RQ19] [RQ20]

  reg [31:0] rd_val;
  always @* begin
    case (wb_adr_i)
      `EPGRF_OFF_FILT:   rd_val = {26'h0, filt};
      `EPGRF_OFF_PCTL:   rd_val = {30'h0, sending, pend};
      `EPGRF_OFF_QUANTA: rd_val = {16'h0, quanta};
      `EPGRF_OFF_STA_LO: rd_val = station[31:0];
      `EPGRF_OFF_STA_HI: rd_val = {16'h0, station[47:32]};
      `EPGRF_OFF_STATUS: rd_val = {29'h0, buf_busy, store_mode, tx_halt};
      default:           rd_val = 32'h0;
    endcase
  end

  reg [31:0] wv;
  always @* begin
    case (wb_adr_i)
      `EPGRF_OFF_FILT:   wv = {26'h0, filt};
      `EPGRF_OFF_QUANTA: wv = {16'h0, quanta};
      `EPGRF_OFF_STA_LO: wv = station[31:0];
      `EPGRF_OFF_STA_HI: wv = {16'h0, station[47:32]};
      default:           wv = 32'h0;
    endcase
    wv = lane_mask(wv, wb_dat_i, wb_sel_i);
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      filt     <= `EPGRF_FILT_RST;                          // [RQ13]
      quanta   <= `EPGRF_QUANTA_RST;
      station  <= 48'h0;
      sw_xon   <= 1'b0;
      sw_xoff  <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_val : 32'h0;
      sw_xon   <= 1'b0;
      sw_xoff  <= 1'b0;
      if (wb_wr) begin
        case (wb_adr_i)
          `EPGRF_OFF_FILT:   filt <= wv[`EPGRF_FILT_W-1:0];
          `EPGRF_OFF_QUANTA: quanta <= wv[15:0];
          `EPGRF_OFF_STA_LO: station[31:0] <= wv;
          `EPGRF_OFF_STA_HI: station[47:32] <= wv[15:0];
          `EPGRF_OFF_PCTL: begin
            sw_xon  <= wb_sel_i[0] & wb_dat_i[`EPGRF_P_XON];  // [RQ2]
            sw_xoff <= wb_sel_i[0] & wb_dat_i[`EPGRF_P_XOFF];
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================
  // Pause request capture and frame generator
  localparam ST_IDLE = 2'b01;
  localparam ST_SEND = 2'b10;

  reg        req_d;
  reg [15:0] p_time;
  reg        p_mcast;
  reg [47:0] p_dst;
  reg [47:0] p_src;
  reg [1:0]  gst;
  reg [2:0]  widx;
  reg [47:0] g_dst;
  reg [47:0] g_src;
  reg [15:0] g_time;

  wire req_edge = pause_req & ~req_d;                       // [RQ4]
  wire start    = pend & ~tx_busy & gst[0];                 // [RQ1] [RQ22]

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      req_d   <= 1'b0;
      pend    <= 1'b0;
      p_time  <= 16'h0;
      p_mcast <= 1'b0;
      p_dst   <= 48'h0;
      p_src   <= 48'h0;
    end else if (ce) begin
      req_d <= pause_req;
      if (req_edge) begin
        pend    <= 1'b1;                                    // [RQ25]
        p_time  <= pause_req_time;                          // [RQ5] [RQ25]
        p_mcast <= pause_req_mcast;
        p_dst   <= pause_req_dst;
        p_src   <= pause_req_src;                           // [RQ7]
      end else if (sw_xon | sw_xoff) begin
        pend    <= 1'b1;                                    // [RQ2]
        p_time  <= sw_xoff ? quanta : 16'h0;                // [RQ3]
        p_mcast <= 1'b1;
        p_src   <= station;
      end else if (start) begin
        pend <= 1'b0;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      gst       <= ST_IDLE;
      widx      <= 3'h0;
      sending   <= 1'b0;
      g_dst     <= 48'h0;
      g_src     <= 48'h0;
      g_time    <= 16'h0;
      gen_data  <= 64'h0;
      gen_valid <= 1'b0;
      gen_sop   <= 1'b0;
      gen_eop   <= 1'b0;
    end else if (ce) begin
      case (gst)
        ST_IDLE: begin
          gen_valid <= 1'b0;
          gen_sop   <= 1'b0;
          gen_eop   <= 1'b0;
          if (start) begin
            g_dst   <= p_mcast ? `EPGRF_MCAST_DA : p_dst;   // [RQ6]
            g_src   <= p_src;                               // [RQ7]
            g_time  <= p_time;                              // [RQ1] [RQ22]
            widx    <= 3'h0;
            sending <= 1'b1;
            gst     <= ST_SEND;
          end
        end
        ST_SEND: begin
          gen_data  <= frame_word(widx, g_dst, g_src, g_time);
          gen_valid <= 1'b1;
          gen_sop   <= (widx == 3'h0);
          gen_eop   <= (widx == `EPGRF_FRAME_LAST);
          widx      <= widx + 3'h1;
          if (widx == `EPGRF_FRAME_LAST) begin
            sending <= 1'b0;
            gst     <= ST_IDLE;
          end
        end
        default: gst <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // TX pause timer
  localparam integer PRE_TOP = `EPGRF_QUANTUM_CYC - 1;

  reg [2:0]  pre;
  reg [15:0] pcnt;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_halt <= 1'b0;
      pre     <= 3'h0;
      pcnt    <= 16'h0;
    end else if (ce) begin
      if (tx_flowctl_hit) begin
        pcnt    <= tx_flowctl_duration;                     // [RQ10] [RQ24]
        pre     <= PRE_TOP[2:0];                            // [RQ23]
        tx_halt <= (tx_flowctl_duration != 16'h0);          // [RQ24]
      end else if (tx_halt) begin
        if (pre == 3'h0) begin
          pre  <= PRE_TOP[2:0];                             // [RQ23]
          pcnt <= pcnt - 16'h1;
          if (pcnt == 16'h1) begin
            tx_halt <= 1'b0;                                // [RQ24]
          end
        end else begin
          pre <= pre - 3'h1;
        end
      end
    end
  end

  // ==========================================
  // RX frame classification
  reg [3:0]  rxi;
  reg [47:0] r_dst;
  reg [15:0] r_type;
  reg [15:0] r_opc;
  reg [15:0] r_qt;

  wire is_ctl   = (r_type == `EPGRF_ETYPE);
  wire is_pause = is_ctl & (r_opc == `EPGRF_OPC_PAUSE);
  wire runt     = (rxi < `EPGRF_MIN_WORDS - 4'h1);
  wire da_ok    = r_dst[40] | (r_dst == station);
  wire drop     = (f_pause & is_pause)                      // [RQ15]
                | (f_ctrl & is_ctl & ~is_pause)             // [RQ16]
                | (f_dst & ~da_ok)                          // [RQ17]
                | (f_runt & runt);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rxi           <= 4'h0;
      r_dst         <= 48'h0;
      r_type        <= 16'h0;
      r_opc         <= 16'h0;
      r_qt          <= 16'h0;
      rx_pause_hit  <= 1'b0;
      rx_pause_time <= 16'h0;
    end else if (ce) begin
      rx_pause_hit <= 1'b0;
      if (rx_valid) begin
        if (rx_sop) begin
          rxi   <= 4'h1;
          r_dst <= rx_data[63:16];
        end else if (rxi != 4'hf) begin
          rxi <= rxi + 4'h1;
        end
        if (~rx_sop & (rxi == 4'h1)) begin
          r_type <= rx_data[31:16];
          r_opc  <= rx_data[15:0];
        end
        if (~rx_sop & (rxi == 4'h2)) begin
          r_qt <= rx_data[63:48];
        end
        if (rx_eop & ~rx_sop & is_pause & ~runt
            & (r_dst == `EPGRF_MCAST_DA | r_dst == station)) begin
          rx_pause_hit  <= 1'b1;                            // [RQ8] [RQ18]
          rx_pause_time <= r_qt;                            // [RQ9]
        end
      end
    end
  end

  // ==========================================
  // Cut-through and store-and-forward path
  reg [`EPGRF_BUF_W-1:0] mem [0:(1<<`EPGRF_BUF_AW)-1];
  reg                    ovf;
  reg                    cut_frame;

  wire sof_store = store_mode | buf_busy;
  wire in_store  = rx_sop ? sof_store : store_frame;        // [RQ20]
  wire in_cut    = rx_sop ? ~sof_store : cut_frame;         // [RQ19]
  wire full      = (wp[8] != rp[8]) & (wp[7:0] == rp[7:0]);

  always @(posedge clk) begin
    if (ce & rx_valid & in_store & ~full) begin
      mem[wp[7:0]] <= {rx_sop, rx_eop, rx_data};
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp          <= 9'h0;
      cp          <= 9'h0;
      ovf         <= 1'b0;
      store_frame <= 1'b0;
      cut_frame   <= 1'b0;
    end else if (ce) begin
      if (rx_valid) begin
        if (rx_sop) begin
          store_frame <= sof_store;
          cut_frame   <= ~sof_store;
        end
        if (in_store) begin
          if (rx_eop) begin
            if (drop | ovf | full) begin
              wp <= cp;                                     // [RQ15] [RQ16]
            end else begin
              wp <= wp + 9'h1;
              cp <= wp + 9'h1;                              // [RQ20]
            end
            ovf <= 1'b0;
          end else if (full) begin
            ovf <= 1'b1;
          end else begin
            wp <= rx_sop ? cp + 9'h1 : wp + 9'h1;
          end
        end
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rp       <= 9'h0;
      cl_data  <= 64'h0;
      cl_valid <= 1'b0;
      cl_sop   <= 1'b0;
      cl_eop   <= 1'b0;
    end else if (ce) begin
      if (rx_valid & in_cut) begin
        cl_data  <= rx_data;                                // [RQ21]
        cl_valid <= 1'b1;
        cl_sop   <= rx_sop;
        cl_eop   <= rx_eop;
      end else if (buf_busy) begin
        cl_data  <= mem[rp[7:0]][63:0];
        cl_valid <= 1'b1;
        cl_sop   <= mem[rp[7:0]][65];
        cl_eop   <= mem[rp[7:0]][64];
        rp       <= rp + 9'h1;
      end else begin
        cl_valid <= 1'b0;
        cl_sop   <= 1'b0;
        cl_eop   <= 1'b0;
      end
    end
  end

endmodule

// [epgrf_top_assertions.sv]
`timescale 1ns/100ps
// ========================================
// Port relations of the flow-control block
module epgrf_chk (
  input wire        clk, // Clock
  input wire        rst, // Reset
  input wire        ce, // Enable
  input wire        wb_cyc_i, // Cycle
  input wire        wb_stb_i, // Strobe
  input wire        wb_ack_o, // Ack
  input wire        gen_valid, // Pause valid
  input wire        gen_sop, // Pause first
  input wire        gen_eop, // Pause last
  input wire [63:0] gen_data, // Pause word
  input wire        tx_flowctl_hit, // Timer load
  input wire [15:0] tx_flowctl_duration, // Timer quanta
  input wire        tx_halt, // Paused
  input wire        rx_valid, // RX valid
  input wire        rx_eop, // RX last
  input wire        rx_pause_hit, // Match
  input wire [15:0] rx_pause_time // Match quanta
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_frame_len: assert property (gen_sop |->
    (gen_valid && !gen_eop) [*7] ##1 (gen_valid && gen_eop))
    else $error("pause frame not eight words");
  chk_frame_type: assert property (gen_sop |=> gen_data[31:0] == 32'h88080001)
    else $error("pause frame type or opcode wrong");
  chk_halt_start: assert property (tx_flowctl_hit |=>
    tx_halt == ($past(tx_flowctl_duration) != 16'h0000))
    else $error("halt does not follow loaded time");
  chk_halt_quantum: assert property ((tx_flowctl_hit && tx_flowctl_duration == 16'h0001)
    ##1 !tx_flowctl_hit [*8] |-> tx_halt ##1 !tx_halt)
    else $error("one quantum not eight cycles");
  chk_hit_eop: assert property (rx_pause_hit |-> $past(rx_valid && rx_eop))
    else $error("match without received frame end");
  chk_time_hold: assert property (!rx_pause_hit |-> $stable(rx_pause_time))
    else $error("pause time moved without match");
endmodule

bind epgrf_top epgrf_chk u_epgrf_chk (.*);

// [epgrf_top_tb.sv]
`timescale 1ns/100ps
`include "epgrf_map.vh"
// ========================================
// Bench
module epgrf_top_tb;
  localparam [47:0] SA = 48'h0a1b2c3d4e5f;
  localparam [47:0] DA = 48'h02a0b0c0d0e1;
  localparam [47:0] MC = `EPGRF_MCAST_DA;
  logic        clk, rst, ce, wb_cyc_i, wb_stb_i, wb_we_i, pause_req, pause_req_mcast, tx_busy;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        wb_ack_o, gen_valid, gen_sop, gen_eop, tx_flowctl_hit, tx_halt;
  logic        rx_valid, rx_sop, rx_eop, rx_pause_hit, cl_valid, cl_sop, cl_eop;
  logic [15:0] pause_req_time, tx_flowctl_duration, rx_pause_time;
  logic [47:0] pause_req_dst, pause_req_src;
  logic [63:0] gen_data, rx_data, cl_data;
  integer      n_mismatch, n_checks, cyc, t_sop, lat, n_cl, n_hit, f0, n, n_cle;
  logic [47:0] cl_da;
  epgrf_top     u_epgrf_top (.*);
  epgrf_partner u_epgrf_partner (.*);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (rx_valid === 1'b1 && rx_sop === 1'b1) t_sop = cyc;
    if (rx_pause_hit === 1'b1) n_hit = n_hit + 1;
    if (cl_valid === 1'b1 && cl_sop === 1'b1) begin
      n_cl = n_cl + 1;
      lat = cyc - t_sop;
      cl_da = cl_data[63:16];
    end
    if (cl_valid === 1'b1 && cl_eop === 1'b1) n_cle = n_cle + 1;
  end
  task chk(input [63:0] e, input [63:0] g, input string s);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch %s expected %h seen %h", s, e, g);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task tmo(input integer i);
    begin
      if (i >= 60) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch wait expected done seen timeout");
        stop_test;
      end
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer i;
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk);
      for (i = 0; i < 60 && wb_ack_o !== 1'b1; i = i + 1) @(posedge clk);
      tmo(i);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
    end
  endtask
  task req;
    begin
      pause_req <= 1'b1;
      @(posedge clk);
      pause_req <= 1'b0;
      @(posedge clk);
    end
  endtask
  task weop;
    integer i;
    begin
      for (i = 0; i < 60 && gen_eop !== 1'b1; i = i + 1) @(posedge clk);
      tmo(i);
      @(posedge clk);
    end
  endtask
  task t_regs;
    begin
      wb(1'b0, `EPGRF_OFF_FILT, 32'h0);
      chk(32'h31, rd, "filter reset");
      wb(1'b0, `EPGRF_OFF_QUANTA, 32'h0);
      chk(32'hffff, rd, "quanta reset");
      wb(1'b1, 8'h40, 32'h5);
      wb(1'b0, 8'h40, 32'h0);
      chk(32'h0, rd, "unmapped");
      $display("test regs done");
    end
  endtask
  task t_client;
    begin
      tx_busy <= 1'b1;
      pause_req_mcast <= 1'b1;
      pause_req_time <= 16'h0;
      req;
      pause_req_mcast <= 1'b0;
      pause_req_time <= 16'h0abc;
      req;
      f0 = u_epgrf_partner.n_frm;
      repeat (20) @(posedge clk);
      chk(f0, u_epgrf_partner.n_frm, "frames while busy");
      wb(1'b0, `EPGRF_OFF_PCTL, 32'h0);
      chk(32'h1, rd, "pending while busy");
      tx_busy <= 1'b0;
      weop;
      chk({DA, SA[47:32]}, u_epgrf_partner.w[0], "word0 unicast");
      chk({SA[31:0], 32'h88080001}, u_epgrf_partner.w[1], "word1");
      chk(16'h0abc, u_epgrf_partner.w[2][63:48], "xoff time");
      repeat (20) @(posedge clk);
      chk(f0 + 1, u_epgrf_partner.n_frm, "one pending frame");
      pause_req_mcast <= 1'b1;
      pause_req_time <= 16'h0;
      req;
      weop;
      chk({MC, SA[47:32]}, u_epgrf_partner.w[0], "word0 multicast");
      chk(16'h0, u_epgrf_partner.w[2][63:48], "xon time");
      $display("test client done");
    end
  endtask
  task t_soft;
    begin
      wb(1'b1, `EPGRF_OFF_QUANTA, 32'h0042);
      wb(1'b1, `EPGRF_OFF_PCTL, 32'h2);
      weop;
      chk(16'h0042, u_epgrf_partner.w[2][63:48], "sw quanta");
      wb(1'b1, `EPGRF_OFF_PCTL, 32'h1);
      weop;
      chk(MC, u_epgrf_partner.w[0][63:16], "sw xon da");
      chk(16'h0, u_epgrf_partner.w[2][63:48], "sw xon time");
      $display("test software done");
    end
  endtask
  task t_rx;
    begin
      u_epgrf_partner.send(MC, 16'h8808, 16'h0001, 16'h0001);
      n = 0;
      repeat (30) begin
        @(posedge clk);
        if (tx_halt === 1'b1) n = n + 1;
      end
      chk(8, n, "halt cycles");
      chk(16'h1, rx_pause_time, "rx time");
      u_epgrf_partner.send(MC, 16'h8808, 16'h0001, 16'hffff);
      repeat (2) @(posedge clk);
      wb(1'b0, `EPGRF_OFF_STATUS, 32'h0);
      chk(32'h3, rd, "status halt store");
      u_epgrf_partner.send(MC, 16'h8808, 16'h0001, 16'h0);
      chk(1'b1, tx_halt, "halt long");
      repeat (6) @(posedge clk);
      chk(1'b0, tx_halt, "zero resumes");
      $display("test rx pause done");
    end
  endtask
  task rxf(input [31:0] f, input [47:0] da, input [15:0] et, input [15:0] op,
           input integer nf, input integer l, input integer h);
    integer c, p, e;
    begin
      wb(1'b1, `EPGRF_OFF_FILT, f);
      c = n_cl;
      p = n_hit;
      e = n_cle;
      lat = 0;
      u_epgrf_partner.send(da, et, op, 16'h0);
      repeat (12) @(posedge clk);
      chk(nf, n_cl - c, "forwarded");
      chk(h, n_hit - p, "pause hit");
      chk(l, lat, "latency");
      chk(nf, n_cle - e, "forwarded ends");
      if (nf != 0) chk(da, cl_da, "forwarded da");
    end
  endtask
  task t_filter;
    begin
      rxf(32'h31, MC, 16'h8808, 16'h0001, 0, 0, 1);
      rxf(32'h31, MC, 16'h8808, 16'h0002, 0, 0, 0);
      rxf(32'h21, DA, 16'h8808, 16'h0001, 1, 9, 0);
      rxf(32'h11, MC, 16'h8808, 16'h0003, 1, 9, 0);
      rxf(32'h30, DA, 16'h8808, 16'h0001, 1, 1, 0);
      rxf(32'h03, DA, 16'h0800, 16'h0000, 1, 1, 0);
      rxf(32'h05, DA, 16'h0800, 16'h0000, 0, 0, 0);
      rxf(32'h25, MC, 16'h8808, 16'h0001, 1, 9, 1);
      $display("test filter done");
    end
  endtask
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    cyc = 0;
    t_sop = 0;
    lat = 0;
    n_cl = 0;
    n_hit = 0;
    n_cle = 0;
    rst = 1'b1;
    ce = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    pause_req = 1'b0;
    pause_req_time = 16'h0;
    pause_req_mcast = 1'b0;
    pause_req_dst = DA;
    pause_req_src = SA;
    tx_busy = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_client;
    t_soft;
    t_rx;
    t_filter;
    stop_test;
  end
endmodule
